/* File: verilog/status_service_request_trigger.sv */
// Status byte, service request, trigger, wait, abort and overcurrent trip logic.
`timescale 1ns/1ps
module status_service_request_trigger #(
  parameter int LevelWidth = 16
) (
  input wire logic clk, // System clock, 250 MHz.
  input wire logic rstn, // Synchronous reset, active low; acts as power-up.
  input wire logic cmdValid, // Command strobe, one cycle.
  input wire logic [3:0] cmdCode, // Command code.
  input wire logic [LevelWidth-1:0] cmdData, // Command argument.
  output logic cmdReady, // High while idle, when a command can be taken.
  output logic respValid, // One-cycle answer strobe.
  output logic [LevelWidth-1:0] respData, // Answer data.
  input wire logic serialPoll, // Serial poll strobe from the controller.
  output logic [7:0] pollByte, // Status byte given on a serial poll.
  output logic pollValid, // One-cycle strobe with pollByte.
  output logic serviceRequest, // Service request line, active high.
  input wire logic deviceClear, // Device clear strobe.
  input wire logic operationSummaryFlag, // Operation summary from its event register.
  input wire logic stdEventSummaryFlag, // Standard event summary.
  input wire logic questionableSummaryIn, // Questionable summary from other sources.
  input wire logic msgEnqueue, // A message entered the output queue.
  input wire logic msgQueueEmpty, // Output queue emptied by reads.
  input wire logic pendingOpsBusy, // Overlapped operations still running.
  input wire logic trigSourceBus, // Trigger source is the bus.
  input wire logic groupExecTrigger, // Group execute trigger strobe.
  input wire logic continuousArmSetting, // Continuous initiation on.
  input wire logic overcurrentProtectEnable, // Overcurrent protection on.
  input wire logic constantCurrentMode, // Output is in constant-current operation.
  input wire logic powerOnClearSetting, // Power-on clear setting.
  input wire logic selfTestFault, // Fault seen during self-test.
  output logic [LevelWidth-1:0] immediateCurrentLevel, // Programmed output current.
  output logic outputEnable, // Output stage enabled.
  output logic overcurrentFlag, // Overcurrent bit of questionable condition.
  output logic waitingForTriggerFlag, // Trigger system armed.
  output logic nvBusy // Nonvolatile write cycle running.
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    StIdle = 2'b00,
    StWait = 2'b01,
    StTest = 2'b10
  } state_t;

  state_t state_r, state_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic rqs_r, rqs_nxt;
  logic mav_r, mav_nxt;
  logic mssPrev_r, mssPrev_nxt;
  logic [LevelWidth-1:0] imm_r, imm_nxt, pend_r, pend_nxt;
  logic pendValid_r, pendValid_nxt;
  logic armed_r, armed_nxt;
  logic outEn_r, outEn_nxt;
  logic oc_r, oc_nxt;
  logic respValid_r, respValid_nxt;
  logic [LevelWidth-1:0] respData_r, respData_nxt;
  logic [7:0] poll_r, poll_nxt;
  logic pollValid_r, pollValid_nxt;
  logic srq_r, srq_nxt;
  logic bootDone_r, bootDone_nxt, ready_r, ready_nxt;
  logic nvWrite, testStart, testDone;
  logic [7:0] nvStored, testResult, stb, stbLive;
  logic master_summary_flag, take, doAbort, doTrig;

  // Build the status byte from its summary sources.
  function automatic logic [7:0] build_stb(input logic operation_summary_flag, input logic mssIn,
    input logic std_event_summary_flag, input logic message_available_flag, input logic questionable_summary_flag);
    logic [7:0] b;
    b = 8'h00;
    b[stat_pkg::OperBit] = operation_summary_flag;
    b[stat_pkg::MssBit] = mssIn;
    b[stat_pkg::EsbBit] = std_event_summary_flag;
    b[stat_pkg::MavBit] = message_available_flag;
    b[stat_pkg::QuesBit] = questionable_summary_flag;
    return b & ~stat_pkg::StbZeroMask;
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  nv_mask_store u_nv (
    .clk(clk),
    .rstn(rstn),
    .writeReq(nvWrite),
    .writeData(mask_nxt),
    .storedVal(nvStored),
    .busy(nvBusy)
  );

  self_test_unit u_test (
    .clk(clk),
    .rstn(rstn),
    .start(testStart),
    .faultIn(selfTestFault),
    .done(testDone),
    .result(testResult)
  );

  // Summary bits except message available (mav_r) and the overcurrent trip (oc_r) are live copies of their sources, so they clear only at the source.
  assign stbLive = build_stb(operationSummaryFlag, 1'b0, stdEventSummaryFlag, mav_r,
    questionableSummaryIn | oc_r);
  assign master_summary_flag = |(stbLive & mask_r);
  assign stb = build_stb(operationSummaryFlag, master_summary_flag, stdEventSummaryFlag, mav_r,
    questionableSummaryIn | oc_r);

  // Commands are taken only in idle; wait and self-test hold them off.
  assign take = cmdValid && (state_r == StIdle) && bootDone_r;
  assign doAbort = !bootDone_r || (take && (cmdCode == stat_pkg::CmdAbort
    || cmdCode == stat_pkg::CmdReset || cmdCode == stat_pkg::CmdRecall));
  assign doTrig = armed_r && trigSourceBus && (groupExecTrigger
    || (take && cmdCode == stat_pkg::CmdBusTrig));
  assign nvWrite = take && cmdCode == stat_pkg::CmdWriteMask && !powerOnClearSetting;
  assign testStart = take && cmdCode == stat_pkg::CmdSelfTest;

  // ****************************************************************
  // Command sequencing and status
  // ****************************************************************
  // Next-state logic for every register of the block.
  always_comb
  begin
    state_nxt = state_r;
    mask_nxt = mask_r;
    rqs_nxt = rqs_r;
    mav_nxt = mav_r;
    mssPrev_nxt = master_summary_flag;
    imm_nxt = imm_r;
    pend_nxt = pend_r;
    pendValid_nxt = pendValid_r;
    armed_nxt = armed_r;
    outEn_nxt = outEn_r;
    oc_nxt = oc_r;
    respValid_nxt = 1'b0;
    respData_nxt = respData_r;
    poll_nxt = poll_r;
    pollValid_nxt = 1'b0;
    bootDone_nxt = 1'b1;
    // Power-up mask comes from the store or is cleared.
    if (!bootDone_r)
      mask_nxt = powerOnClearSetting ? stat_pkg::MaskResetVal : nvStored;
    // Wait and self-test states.
    case (state_r)
      StIdle:
        state_nxt = StIdle;
      StWait:
        if (deviceClear || !pendingOpsBusy)
          state_nxt = StIdle;
      StTest:
        if (testDone)
        begin
          state_nxt = StIdle;
          respValid_nxt = 1'b1;
          respData_nxt = LevelWidth'(testResult);
        end
      default:
        state_nxt = StIdle;
    endcase
    if (take)
    begin
      case (cmdCode)
        stat_pkg::CmdWriteMask:
          mask_nxt = cmdData[7:0];
        stat_pkg::CmdReadMask:
        begin
          respValid_nxt = 1'b1;
          respData_nxt = LevelWidth'(mask_r);
        end
        stat_pkg::CmdReadStb:
        begin
          respValid_nxt = 1'b1;
          respData_nxt = LevelWidth'(stb);
        end
        stat_pkg::CmdSelfTest:
          state_nxt = StTest;
        stat_pkg::CmdWait:
          if (pendingOpsBusy)
            state_nxt = StWait;
        stat_pkg::CmdSetImm:
          imm_nxt = cmdData;
        stat_pkg::CmdSetPend:
        begin
          pend_nxt = cmdData;
          pendValid_nxt = 1'b1;
        end
        stat_pkg::CmdReadPend:
        begin
          respValid_nxt = 1'b1;
          respData_nxt = pendValid_r ? pend_r : imm_r;
        end
        stat_pkg::CmdInit:
          armed_nxt = 1'b1;
        stat_pkg::CmdProtClear:
        begin
          oc_nxt = 1'b0;
          outEn_nxt = 1'b1;
        end
        stat_pkg::CmdClearStatus:
          mav_nxt = 1'b0;
        default:
          state_nxt = state_nxt;
      endcase
    end
    // Message available clears only at reset or clear-status; an emptied queue leaves it set.
    if (msgEnqueue)
      mav_nxt = 1'b1;
    // Trigger transfers the pending level; single-shot arming is consumed.
    if (doTrig)
    begin
      if (pendValid_r)
        imm_nxt = pend_r;
      pendValid_nxt = 1'b0;
      pend_nxt = imm_nxt;
      armed_nxt = continuousArmSetting;
    end
    // Abort discards pending levels and re-arms only in continuous mode.
    if (doAbort)
    begin
      pend_nxt = imm_nxt;
      pendValid_nxt = 1'b0;
      armed_nxt = continuousArmSetting;
    end
    if (continuousArmSetting)
      armed_nxt = 1'b1;
    // Overcurrent trip; a trip in the clear cycle wins.
    if (overcurrentProtectEnable && constantCurrentMode && outEn_r)
    begin
      outEn_nxt = 1'b0;
      oc_nxt = 1'b1;
    end
    // Request flag rises on a new master summary; poll clears it unless one arrives.
    if (serialPoll)
    begin
      poll_nxt = {stb[7], rqs_r, stb[5:0]};
      pollValid_nxt = 1'b1;
      rqs_nxt = 1'b0;
    end
    if (master_summary_flag && !mssPrev_r)
      rqs_nxt = 1'b1;
    if (mask_r == 8'h00)
      rqs_nxt = 1'b0;
    srq_nxt = rqs_nxt;
    ready_nxt = (state_nxt == StIdle);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Register update; the stored mask itself lives in the nonvolatile store.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= StIdle;
      mask_r <= stat_pkg::MaskResetVal;
      rqs_r <= 1'b0;
      mav_r <= 1'b0;
      mssPrev_r <= 1'b0;
      imm_r <= LevelWidth'(stat_pkg::LevelResetVal);
      pend_r <= LevelWidth'(stat_pkg::LevelResetVal);
      pendValid_r <= 1'b0;
      armed_r <= 1'b0;
      outEn_r <= 1'b0;
      oc_r <= 1'b0;
      respValid_r <= 1'b0;
      respData_r <= '0;
      poll_r <= 8'h00;
      pollValid_r <= 1'b0;
      srq_r <= 1'b0;
      bootDone_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      mask_r <= mask_nxt;
      rqs_r <= rqs_nxt;
      mav_r <= mav_nxt;
      mssPrev_r <= mssPrev_nxt;
      imm_r <= imm_nxt;
      pend_r <= pend_nxt;
      pendValid_r <= pendValid_nxt;
      armed_r <= armed_nxt;
      outEn_r <= outEn_nxt;
      oc_r <= oc_nxt;
      respValid_r <= respValid_nxt;
      respData_r <= respData_nxt;
      poll_r <= poll_nxt;
      pollValid_r <= pollValid_nxt;
      srq_r <= srq_nxt;
      bootDone_r <= bootDone_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign cmdReady = ready_r;
  assign respValid = respValid_r;
  assign respData = respData_r;
  assign pollByte = poll_r;
  assign pollValid = pollValid_r;
  assign serviceRequest = srq_r;
  assign immediateCurrentLevel = imm_r;
  assign outputEnable = outEn_r;
  assign overcurrentFlag = oc_r;
  assign waitingForTriggerFlag = armed_r;

endmodule

/* File: shared/stat_pkg.sv */
// Package with the constants and types shared by the status, trigger and protection logic.
package stat_pkg;

  // ****************************************************************
  // Status summary byte layout
  // ****************************************************************
  localparam int OperBit = 7;
  localparam int MssBit = 6;
  localparam int EsbBit = 5;
  localparam int MavBit = 4;
  localparam int QuesBit = 3;
  localparam logic [7:0] StbZeroMask = 8'h07;

  // ****************************************************************
  // Reset values and self-test result codes
  // ****************************************************************
  localparam logic [7:0] MaskResetVal = 8'h00;
  localparam logic [7:0] SelfTestPassCode = 8'h00;
  localparam logic [7:0] SelfTestFailCode = 8'h01;
  localparam logic PscResetVal = 1'b1;
  localparam logic [15:0] LevelResetVal = 16'h0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ClkPeriodNs = 4;
  localparam int NvWriteTimeNs = 400;
  localparam int NvWriteCycles = (NvWriteTimeNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int SelfTestTimeNs = 200;
  localparam int SelfTestCycles = (SelfTestTimeNs + ClkPeriodNs - 1) / ClkPeriodNs;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  typedef enum logic [3:0] {
    CmdNone = 4'h0,
    CmdWriteMask = 4'h1,
    CmdReadStb = 4'h2,
    CmdBusTrig = 4'h3,
    CmdSelfTest = 4'h4,
    CmdWait = 4'h5,
    CmdAbort = 4'h6,
    CmdReset = 4'h7,
    CmdRecall = 4'h8,
    CmdSetImm = 4'h9,
    CmdSetPend = 4'ha,
    CmdReadPend = 4'hb,
    CmdInit = 4'hc,
    CmdProtClear = 4'hd,
    CmdClearStatus = 4'he,
    CmdReadMask = 4'hf
  } cmd_t;

endpackage

/* File: verilog/nv_mask_store.sv */
// Nonvolatile store model for the service request mask with a busy write cycle.
`timescale 1ns/1ps
module nv_mask_store #(
  parameter int WriteCycles = stat_pkg::NvWriteCycles
) (
  input wire logic clk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic writeReq, // One-cycle request to commit a value.
  input wire logic [7:0] writeData, // Value to commit.
  output logic [7:0] storedVal, // Last committed value.
  output logic busy // High while a write cycle runs.
);

  logic [7:0] store_r, store_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;

  // A write restarts the cycle; the stored value survives the system reset.
  always_comb
  begin
    store_nxt = store_r;
    cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
    if (writeReq)
    begin
      store_nxt = writeData;
      cnt_nxt = 16'(WriteCycles);
    end
    busy_nxt = (cnt_nxt != 16'h0000);
  end

  // The array cell is not reset, so a stored mask outlives rstn.
  always_ff @(posedge clk)
  begin
    store_r <= store_nxt;
    if (!rstn)
    begin
      cnt_r <= 16'h0000;
      busy_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign storedVal = store_r;
  assign busy = busy_r;

endmodule

/* File: verilog/self_test_unit.sv */
// Self-test sequencer that runs for a fixed time and reports a result code.
`timescale 1ns/1ps
module self_test_unit #(
  parameter int TestCycles = stat_pkg::SelfTestCycles
) (
  input wire logic clk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic start, // One-cycle start pulse.
  input wire logic faultIn, // Fault seen by the test hardware.
  output logic done, // One-cycle pulse when finished.
  output logic [7:0] result // Zero on pass, error code otherwise.
);

  logic [15:0] cnt_r, cnt_nxt;
  logic fail_r, fail_nxt;
  logic done_r, done_nxt;

  // Count down and collect any fault seen during the run.
  always_comb
  begin
    cnt_nxt = cnt_r;
    fail_nxt = fail_r;
    done_nxt = 1'b0;
    if (start)
    begin
      cnt_nxt = 16'(TestCycles);
      fail_nxt = faultIn;
    end
    else if (cnt_r != 16'h0000)
    begin
      cnt_nxt = cnt_r - 16'h0001;
      fail_nxt = fail_r | faultIn;
      done_nxt = (cnt_r == 16'h0001);
    end
  end

  // Register the sequencer state.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_r <= 16'h0000;
      fail_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      fail_r <= fail_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign result = fail_r ? stat_pkg::SelfTestFailCode : stat_pkg::SelfTestPassCode;

endmodule

/* File: dv/status_chk.sv */
// Port-level checker for the status, trigger and protection block.
`timescale 1ns/1ps
module status_chk #(
  parameter int LevelWidth = 16
) (
  input wire logic clk, // System clock.
  input wire logic rstn, // Reset, active low.
  input wire logic cmdValid, // Command strobe.
  input wire logic [3:0] cmdCode, // Command code.
  input wire logic cmdReady, // Command accept.
  input wire logic respValid, // Answer strobe.
  input wire logic [LevelWidth-1:0] respData, // Answer data.
  input wire logic serialPoll, // Poll strobe in.
  input wire logic [7:0] pollByte, // Poll byte.
  input wire logic pollValid, // Poll strobe out.
  input wire logic serviceRequest, // Request line.
  input wire logic pendingOpsBusy, // Overlapped work running.
  input wire logic continuousArmSetting, // Continuous arming.
  input wire logic overcurrentProtectEnable, // Protection on.
  input wire logic constantCurrentMode, // Constant-current operation.
  input wire logic outputEnable, // Output stage on.
  input wire logic overcurrentFlag, // Trip flag.
  input wire logic waitingForTriggerFlag // Armed flag.
);
  // ****************************************
  // Helpers and assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic take;
  // A command counts only on the edge where it is accepted.
  assign take = cmdValid && cmdReady;
  a_poll_answer: assert property (serialPoll |=> pollValid && pollByte[2:0] == 3'h0)
    else $error("poll answer missing or low bits set");
  a_poll_bit6: assert property (pollValid |-> pollByte[6] == $past(serviceRequest))
    else $error("poll bit 6 differs from request line");
  a_poll_clears: assert property (serialPoll ##1 pollValid |-> ##[0:1] !serviceRequest)
    else $error("request line still up after poll");
  a_stb_query: assert property (take && cmdCode == stat_pkg::CmdReadStb
    |=> respValid && respData[2:0] == 3'h0)
    else $error("status query answer wrong");
  a_wait_stall: assert property (take && cmdCode == stat_pkg::CmdWait && pendingOpsBusy
    |-> ##[1:2] !cmdReady)
    else $error("wait did not stall commands");
  a_trip_output: assert property (overcurrentProtectEnable && constantCurrentMode && outputEnable
    |=> !outputEnable && overcurrentFlag)
    else $error("overcurrent trip missing");
  a_abort_disarm: assert property (take && cmdCode == stat_pkg::CmdAbort && !continuousArmSetting
    |=> !waitingForTriggerFlag)
    else $error("abort left trigger armed");
  a_abort_rearm: assert property (take && cmdCode == stat_pkg::CmdAbort && continuousArmSetting
    |-> ##[1:2] waitingForTriggerFlag)
    else $error("continuous arming did not re-arm");
  a_boot_ready: assert property ($rose(rstn) |-> ##[1:3] cmdReady)
    else $error("no command accept after boot");
  c_poll_req: cover property (pollValid && pollByte[6]);
  c_wait: cover property (take && cmdCode == stat_pkg::CmdWait && pendingOpsBusy);
  c_trip: cover property (overcurrentFlag && !outputEnable);
endmodule
bind status_service_request_trigger status_chk #(.LevelWidth(LevelWidth)) u_chk (.clk,
  .rstn, .cmdValid, .cmdCode, .cmdReady, .respValid, .respData, .serialPoll, .pollByte,
  .pollValid, .serviceRequest, .pendingOpsBusy, .continuousArmSetting,
  .overcurrentProtectEnable, .constantCurrentMode, .outputEnable, .overcurrentFlag,
  .waitingForTriggerFlag);

/* File: dv/bus_ctrl_model.sv */
// Bus controller model that issues serial polls and device clears.
`timescale 1ns/1ps
module bus_ctrl_model (
  input wire logic clk, // System clock.
  input wire logic rstn, // Reset, active low.
  input wire logic pollGo, // Bench asks for a serial poll.
  input wire logic clearGo, // Bench asks for a device clear.
  output logic serialPoll, // Poll strobe to the device.
  output logic deviceClear // Clear strobe to the device.
);
  // Strobes are registered so they change just after an edge, never mid-cycle.
  always_ff @(posedge clk)
  begin
    serialPoll <= rstn && pollGo;
    deviceClear <= rstn && clearGo;
  end
endmodule

/* File: dv/status_service_request_trigger_test.sv */
// Self-checking testbench for the status, trigger and protection block.
`timescale 1ns/1ps
module status_service_request_trigger_test;
  logic clk, rstn, cmdValid, cmdReady, respValid, pollValid, serviceRequest, nvBusy;
  logic serialPoll, deviceClear, pollGo, clearGo, operationSummaryFlag, stdEventSummaryFlag;
  logic questionableSummaryIn, msgEnqueue, msgQueueEmpty, pendingOpsBusy, trigSourceBus;
  logic groupExecTrigger, continuousArmSetting, overcurrentProtectEnable, constantCurrentMode;
  logic powerOnClearSetting, selfTestFault, outputEnable, overcurrentFlag, waitingForTriggerFlag;
  logic [3:0] cmdCode;
  logic [15:0] cmdData, respData, immediateCurrentLevel;
  logic [7:0] pollByte, m, s, e;
  logic [15:0] respQ[$];
  logic [7:0] pollQ[$];
  int badCount, testsRun;
  status_service_request_trigger u_dut (.clk, .rstn, .cmdValid, .cmdCode, .cmdData, .cmdReady,
    .respValid, .respData, .serialPoll, .pollByte, .pollValid, .serviceRequest, .deviceClear,
    .operationSummaryFlag, .stdEventSummaryFlag, .questionableSummaryIn, .msgEnqueue,
    .msgQueueEmpty, .pendingOpsBusy, .trigSourceBus, .groupExecTrigger, .continuousArmSetting,
    .overcurrentProtectEnable, .constantCurrentMode, .powerOnClearSetting, .selfTestFault,
    .immediateCurrentLevel, .outputEnable, .overcurrentFlag, .waitingForTriggerFlag, .nvBusy);
  bus_ctrl_model u_ctrl (.clk, .rstn, .pollGo, .clearGo, .serialPoll, .deviceClear);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    testsRun++;
    if (got !== exp)
    begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Waits for the accept line away from the edge, so a stall from the last command is seen.
  task automatic cmd(stat_pkg::cmd_t c, logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (cmdReady !== 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) badCount++;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdData <= d;
    @(posedge clk);
    cmdValid <= 1'b0;
  endtask
  task automatic ask(stat_pkg::cmd_t c, logic [15:0] x);
    respQ.push_back(x);
    cmd(c, 16'h0000);
  endtask
  task automatic poll(logic [7:0] x);
    pollQ.push_back(x);
    @(posedge clk) pollGo <= 1'b1;
    @(posedge clk) pollGo <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (respQ.size() > 0 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) badCount++;
  endtask
  // Each answer is matched against the oldest note left by the driver.
  always @(posedge clk)
  begin
    if (respValid === 1'b1)
      check("respData", respQ.size() > 0 ? respQ.pop_front() : 16'hxxxx, respData);
    if (pollValid === 1'b1)
      check("pollByte", {8'h00, pollQ.size() > 0 ? pollQ.pop_front() : 8'hxx}, {8'h00, pollByte});
  end
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The limit is generous against the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    badCount++;
    $display("watchdog expired");
    tally_and_finish();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rstn, cmdValid, pollGo, clearGo, operationSummaryFlag, stdEventSummaryFlag} = '0;
    {questionableSummaryIn, msgEnqueue, msgQueueEmpty, pendingOpsBusy, trigSourceBus} = '0;
    {groupExecTrigger, continuousArmSetting, overcurrentProtectEnable, constantCurrentMode} = '0;
    {selfTestFault, cmdCode, cmdData} = '0;
    powerOnClearSetting = 1'b1;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    void'($urandom(20));
    ask(stat_pkg::CmdReadMask, 16'h0000);
    @(posedge clk) powerOnClearSetting <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 3) ? 8'h00 : 8'($urandom());
      cmd(stat_pkg::CmdWriteMask, {8'h00, m});
      repeat (3) @(negedge clk);
      check("nvBusy", 16'h0001, {15'h0, nvBusy});
      ask(stat_pkg::CmdReadMask, {8'h00, m});
      s = 8'($urandom()) & 8'hb8;
      @(posedge clk);
      operationSummaryFlag <= s[7];
      stdEventSummaryFlag <= s[5];
      questionableSummaryIn <= s[3];
      msgEnqueue <= s[4];
      @(posedge clk) {msgEnqueue, msgQueueEmpty} <= 2'b01;
      @(posedge clk) msgQueueEmpty <= 1'b0;
      repeat (4) @(posedge clk);
      e = s | {1'b0, |(s & m), 6'h00};
      ask(stat_pkg::CmdReadStb, {8'h00, e});
      poll(e);
      poll(e & 8'hbf);
      ask(stat_pkg::CmdReadStb, {8'h00, e});
      cmd(stat_pkg::CmdClearStatus, 16'h0000);
      e = s & 8'ha8;
      e[6] = |(e & m);
      ask(stat_pkg::CmdReadStb, {8'h00, e});
      @(posedge clk) {operationSummaryFlag, stdEventSummaryFlag, questionableSummaryIn} <= 3'h0;
      repeat (4) @(posedge clk);
    end
    $display("status and poll test done");
    cmd(stat_pkg::CmdWriteMask, 16'h0024);
    @(posedge clk) rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    ask(stat_pkg::CmdReadMask, 16'h0024);
    @(posedge clk) trigSourceBus <= 1'b1;
    cmd(stat_pkg::CmdSetImm, 16'h0100);
    cmd(stat_pkg::CmdSetPend, 16'h0200);
    cmd(stat_pkg::CmdSetImm, 16'h0300);
    ask(stat_pkg::CmdReadPend, 16'h0200);
    cmd(stat_pkg::CmdBusTrig, 16'h0000);
    repeat (2) @(negedge clk);
    check("level", 16'h0300, immediateCurrentLevel);
    cmd(stat_pkg::CmdInit, 16'h0000);
    @(posedge clk) trigSourceBus <= 1'b0;
    cmd(stat_pkg::CmdBusTrig, 16'h0000);
    repeat (2) @(negedge clk);
    check("level", 16'h0300, immediateCurrentLevel);
    check("armed", 16'h0001, {15'h0, waitingForTriggerFlag});
    @(posedge clk) trigSourceBus <= 1'b1;
    @(posedge clk) groupExecTrigger <= 1'b1;
    @(posedge clk) groupExecTrigger <= 1'b0;
    repeat (2) @(negedge clk);
    check("level", 16'h0200, immediateCurrentLevel);
    cmd(stat_pkg::CmdInit, 16'h0000);
    cmd(stat_pkg::CmdSetPend, 16'h0400);
    cmd(stat_pkg::CmdAbort, 16'h0000);
    ask(stat_pkg::CmdReadPend, 16'h0200);
    check("armed", 16'h0000, {15'h0, waitingForTriggerFlag});
    @(posedge clk) continuousArmSetting <= 1'b1;
    cmd(stat_pkg::CmdAbort, 16'h0000);
    repeat (3) @(negedge clk);
    check("armed", 16'h0001, {15'h0, waitingForTriggerFlag});
    @(posedge clk) continuousArmSetting <= 1'b0;
    cmd(stat_pkg::CmdRecall, 16'h0000);
    repeat (2) @(negedge clk);
    check("armed", 16'h0000, {15'h0, waitingForTriggerFlag});
    cmd(stat_pkg::CmdInit, 16'h0000);
    cmd(stat_pkg::CmdReset, 16'h0000);
    repeat (2) @(negedge clk);
    check("armed", 16'h0000, {15'h0, waitingForTriggerFlag});
    $display("trigger test done");
    @(posedge clk) pendingOpsBusy <= 1'b1;
    cmd(stat_pkg::CmdWait, 16'h0000);
    repeat (5) @(negedge clk);
    check("ready", 16'h0000, {15'h0, cmdReady});
    @(posedge clk) clearGo <= 1'b1;
    @(posedge clk) clearGo <= 1'b0;
    repeat (4) @(negedge clk);
    check("ready", 16'h0001, {15'h0, cmdReady});
    cmd(stat_pkg::CmdWait, 16'h0000);
    @(negedge clk) check("ready", 16'h0000, {15'h0, cmdReady});
    @(posedge clk) pendingOpsBusy <= 1'b0;
    repeat (4) @(negedge clk);
    check("ready", 16'h0001, {15'h0, cmdReady});
    for (int f = 0; f < 2; f++)
    begin
      @(posedge clk) selfTestFault <= f[0];
      ask(stat_pkg::CmdSelfTest, {8'h00, f[0] ? stat_pkg::SelfTestFailCode
        : stat_pkg::SelfTestPassCode});
      drain();
    end
    $display("wait and self-test done");
    cmd(stat_pkg::CmdProtClear, 16'h0000);
    repeat (2) @(negedge clk);
    check("outEn", 16'h0001, {15'h0, outputEnable});
    @(posedge clk);
    overcurrentProtectEnable <= 1'b1;
    constantCurrentMode <= 1'b1;
    repeat (3) @(negedge clk);
    check("outEn", 16'h0000, {15'h0, outputEnable});
    check("trip", 16'h0001, {15'h0, overcurrentFlag});
    ask(stat_pkg::CmdReadStb, 16'h0008);
    @(posedge clk) constantCurrentMode <= 1'b0;
    cmd(stat_pkg::CmdProtClear, 16'h0000);
    repeat (2) @(negedge clk);
    check("trip", 16'h0000, {15'h0, overcurrentFlag});
    check("outEn", 16'h0001, {15'h0, outputEnable});
    drain();
    $display("protection test done");
    tally_and_finish();
  end
endmodule
